//--- logic/reset_power_pkg.sv
package reset_power_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int RESET_HOLD_NS   = 400;
  localparam int RESET_HOLD_CYC  = (RESET_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // reset cause register
  // ----------------------------------------------------------------
  typedef struct packed {
    logic powerOnFlag;
    logic brownoutCauseFlag;
    logic watchdogFlag;
    logic softwareFlag;
    logic breakCharFlag;
    logic externalPinFlag;
  } cause_t;

  localparam cause_t CAUSE_RESET_VALUE = 6'h30;
  localparam logic [15:0] ZERO_FETCH   = 16'h0000;
  localparam logic [7:0]  BOOT_LOW     = 8'h00;

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_RUN    = 4'h1,
    MODE_IDLE   = 4'h2,
    MODE_PDOWN  = 4'h4,
    MODE_TPDOWN = 4'h8
  } power_mode_t;

  typedef struct packed {
    logic idle;
    logic powerDown;
    logic totalPowerDown;
  } mode_req_t;

  typedef struct packed {
    logic cpuClock;
    logic peripheralClock;
    logic mainOsc;
    logic rcOsc;
    logic brownoutDetector;
    logic comparators;
    logic watchdog;
    logic rtc;
  } power_ctl_t;

  localparam power_ctl_t POWER_CTL_RESET = 8'hFA;

endpackage

//--- logic/reset_power_supervisor.sv
`timescale 1ns/1ns
module reset_power_supervisor #(
  parameter int RESET_HOLD_CYCLES = reset_power_pkg::RESET_HOLD_CYC
) (
  // clock and supervisor reset (power-on of this logic)
  input  wire logic                         clock,
  input  wire logic                         resetn,
  // supply monitors and shared pin
  input  wire logic                         powerOnRaw,
  input  wire logic                         brownoutRaw,
  input  wire logic                         sharedResetPin,
  // configuration
  input  wire logic                         resetPinEnable,
  input  wire logic                         brownoutEnableConfig,
  input  wire logic                         brownoutAsInterrupt,
  input  wire logic [7:0]                   bootStatusByte,
  input  wire logic [7:0]                   bootVector,
  input  wire logic                         inSystemProgrammingMode,
  // other reset sources
  input  wire logic                         watchdogReset,
  input  wire logic                         softwareReset,
  input  wire logic                         breakReset,
  // software access to flags
  input  wire logic                         causeWrite,
  input  wire reset_power_pkg::cause_t      causeWriteData,
  input  wire logic                         brownoutIrqClear,
  // power mode control
  input  wire reset_power_pkg::mode_req_t   modeRequest,
  input  wire logic                         interruptPending,
  input  wire logic                         wakeInterrupt,
  input  wire logic                         rcIsSystemClock,
  input  wire logic                         rtcEnable,
  input  wire logic                         comparatorPowerOff,
  // results
  output reset_power_pkg::cause_t           resetCauseRegister,
  output logic                              cpuResetn,
  output logic                              brownoutIrq,
  output logic [15:0]                       fetchAddress,
  output logic                              pinDigitalIn,
  output reset_power_pkg::power_mode_t      powerMode,
  output reset_power_pkg::power_ctl_t       powerCtl
);

  localparam int HOLD_W = $clog2(RESET_HOLD_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RESET_HOLD_CYCLES);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [2:0] rawSync1;
  logic [2:0] rawSync2;
  logic       powerOnSync;
  logic       brownoutSync;
  logic       pinSync;

  // stage one is read only by stage two
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rawSync1 <= 3'h5;
      rawSync2 <= 3'h5;
    end else begin
      rawSync1 <= {powerOnRaw, brownoutRaw, sharedResetPin};
      rawSync2 <= rawSync1;
    end
  end

  assign powerOnSync  = rawSync2[2];
  assign brownoutSync = rawSync2[1];
  assign pinSync      = rawSync2[0];

  // ----------------------------------------------------------------
  // source decode
  // ----------------------------------------------------------------
  logic powerUpPhase;
  logic brownoutDetect;
  logic extReq;
  logic brownoutReq;
  logic anyReq;
  logic [HOLD_W-1:0] holdCount;
  logic breakEpisode;
  logic programLatch;
  logic bootSelect;

  function automatic logic isPowerDown(input reset_power_pkg::power_mode_t m);
    return (m == reset_power_pkg::MODE_PDOWN) || (m == reset_power_pkg::MODE_TPDOWN);
  endfunction

  // detector dead in total power-down, gated by software enable
  assign brownoutDetect = brownoutSync && brownoutEnableConfig
                          && (powerMode != reset_power_pkg::MODE_TPDOWN);
  // default is reset; interrupt option suppresses it
  assign brownoutReq = brownoutDetect && !brownoutAsInterrupt;
  // power-up forces the pin to reset duty whatever the enable says
  assign extReq = !pinSync && (resetPinEnable || powerUpPhase);
  assign anyReq = extReq || powerOnSync || brownoutReq || watchdogReset
                  || softwareReset || breakReset;

  // ----------------------------------------------------------------
  // internal reset stretch
  // ----------------------------------------------------------------
  // a board holding the pin low at power-up keeps us here forever
  always_ff @(posedge clock) begin
    if (!resetn) begin
      holdCount <= HOLD_LOAD;
    end else if (anyReq) begin
      holdCount <= HOLD_LOAD;
    end else if (holdCount != '0) begin
      holdCount <= holdCount - 1'b1;
    end
  end

  // released only on a clock edge after the stretch runs out
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cpuResetn <= 1'b0;
    end else begin
      cpuResetn <= !anyReq && (holdCount == '0);
    end
  end

  // power-up phase lasts until the first release
  always_ff @(posedge clock) begin
    if (!resetn || powerOnSync) begin
      powerUpPhase <= 1'b1;
    end else if (!anyReq && holdCount == '0) begin
      powerUpPhase <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // cause flags
  // ----------------------------------------------------------------
  reset_power_pkg::cause_t newCause;
  reset_power_pkg::cause_t next_cause;

  always_comb begin
    newCause                   = '0;
    newCause.brownoutCauseFlag = brownoutReq;
    newCause.watchdogFlag      = watchdogReset;
    newCause.softwareFlag      = softwareReset;
    newCause.breakCharFlag     = breakReset;
    newCause.externalPinFlag   = extReq;
    // writing zero clears; a new event in the same cycle wins
    next_cause = (causeWrite ? (resetCauseRegister & causeWriteData)
                             : resetCauseRegister) | newCause;
  end

  always_ff @(posedge clock) begin
    if (!resetn || powerOnSync) begin
      resetCauseRegister <= reset_power_pkg::CAUSE_RESET_VALUE;
    end else begin
      resetCauseRegister <= next_cause;
    end
  end

  // sticky brownout interrupt, set beats clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      brownoutIrq <= 1'b0;
    end else if (brownoutDetect && brownoutAsInterrupt) begin
      brownoutIrq <= 1'b1;
    end else if (brownoutIrqClear) begin
      brownoutIrq <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // reset vector
  // ----------------------------------------------------------------
  // break marks the episode it starts or joins
  always_ff @(posedge clock) begin
    if (!resetn) begin
      breakEpisode <= 1'b0;
    end else if (anyReq && cpuResetn) begin
      breakEpisode <= breakReset;
    end else if (breakReset) begin
      breakEpisode <= 1'b1;
    end
  end

  // programming mode only counts when forced during power-up
  always_ff @(posedge clock) begin
    if (!resetn || powerUpPhase) begin
      programLatch <= inSystemProgrammingMode;
    end else if (anyReq && cpuResetn) begin
      programLatch <= 1'b0;
    end
  end

  assign bootSelect = breakEpisode || bootStatusByte[0] || programLatch;

  // tracked through the whole stretch, frozen at release
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fetchAddress <= reset_power_pkg::ZERO_FETCH;
    end else if (anyReq || holdCount != '0) begin
      fetchAddress <= bootSelect ? {bootVector, reset_power_pkg::BOOT_LOW}
                                 : reset_power_pkg::ZERO_FETCH;
    end
  end

  // shared pin reads as plain input only when not doing reset duty
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pinDigitalIn <= 1'b1;
    end else begin
      pinDigitalIn <= (resetPinEnable || powerUpPhase) ? 1'b1 : pinSync;
    end
  end

  // ----------------------------------------------------------------
  // power mode machine
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn || anyReq) begin
      powerMode <= reset_power_pkg::MODE_RUN;
    end else begin
      unique case (powerMode)
        reset_power_pkg::MODE_RUN: begin
          if (cpuResetn && modeRequest.totalPowerDown) begin
            powerMode <= reset_power_pkg::MODE_TPDOWN;
          end else if (cpuResetn && modeRequest.powerDown) begin
            powerMode <= reset_power_pkg::MODE_PDOWN;
          end else if (cpuResetn && modeRequest.idle) begin
            powerMode <= reset_power_pkg::MODE_IDLE;
          end
        end
        reset_power_pkg::MODE_IDLE: begin
          if (interruptPending || wakeInterrupt || brownoutIrq) begin
            powerMode <= reset_power_pkg::MODE_RUN;
          end
        end
        reset_power_pkg::MODE_PDOWN,
        reset_power_pkg::MODE_TPDOWN: begin
          if (wakeInterrupt) begin
            powerMode <= reset_power_pkg::MODE_RUN;
          end
        end
        default: begin
          powerMode <= reset_power_pkg::MODE_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power gating outputs
  // ----------------------------------------------------------------
  reset_power_pkg::power_ctl_t next_powerCtl;
  logic lowPower;

  always_comb begin
    lowPower                       = isPowerDown(powerMode);
    next_powerCtl.cpuClock         = (powerMode == reset_power_pkg::MODE_RUN);
    next_powerCtl.peripheralClock  = !lowPower;
    next_powerCtl.mainOsc          = !lowPower;
    // rc kept only when it clocks a running timer in power-down
    next_powerCtl.rcOsc            = lowPower ? (rcIsSystemClock && rtcEnable)
                                              : rcIsSystemClock;
    next_powerCtl.brownoutDetector = brownoutEnableConfig
                                     && (powerMode != reset_power_pkg::MODE_TPDOWN);
    next_powerCtl.comparators      = !comparatorPowerOff
                                     && (powerMode != reset_power_pkg::MODE_TPDOWN);
    next_powerCtl.watchdog         = 1'b1;
    next_powerCtl.rtc              = rtcEnable;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      powerCtl <= reset_power_pkg::POWER_CTL_RESET;
    end else begin
      powerCtl <= next_powerCtl;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  brownout_reset_a: assert property (brownoutDetect && !brownoutAsInterrupt |=> !cpuResetn)
    else $error("brownout did not reset");
  brownout_enable_a: assert property (
      (brownoutSync && !brownoutEnableConfig && !anyReq && !causeWrite)
      |=> !resetCauseRegister.brownoutCauseFlag || $past(resetCauseRegister.brownoutCauseFlag))
    else $error("disabled brownout set its flag");
  brownout_irq_a: assert property (
      brownoutDetect && brownoutAsInterrupt
      |=> brownoutIrq ##1 (brownoutIrq || $past(brownoutIrqClear)))
    else $error("brownout interrupt not raised");
  power_flags_a: assert property (powerOnSync |=> resetCauseRegister == 6'h30)
    else $error("power-on flags wrong");
  power_sticky_a: assert property (
      resetCauseRegister.powerOnFlag && !(causeWrite && !causeWriteData.powerOnFlag)
      |=> resetCauseRegister.powerOnFlag)
    else $error("power-on flag lost");
  flag_clear_a: assert property (
      causeWrite && !causeWriteData.watchdogFlag && !watchdogReset && !powerOnSync
      |=> !resetCauseRegister.watchdogFlag)
    else $error("watchdog flag not cleared");
  flags_kept_a: assert property (
      softwareReset && !powerOnSync && !causeWrite
      |=> resetCauseRegister.softwareFlag
          && ((resetCauseRegister & $past(resetCauseRegister)) == $past(resetCauseRegister)))
    else $error("flags not kept");
  pin_reset_a: assert property (
      !pinSync && resetPinEnable |=> !cpuResetn ##1 !cpuResetn)
    else $error("reset pin ignored");
  release_sync_a: assert property (anyReq |=> !cpuResetn [*3])
    else $error("reset released too early");
  idle_exit_a: assert property (
      powerMode == reset_power_pkg::MODE_IDLE && interruptPending
      |=> powerMode == reset_power_pkg::MODE_RUN ##1 powerCtl.cpuClock)
    else $error("idle not left");
  pdown_osc_a: assert property (
      isPowerDown(powerMode) |=> !powerCtl.mainOsc && powerCtl.watchdog)
    else $error("oscillator running in power-down");
  tpd_off_a: assert property (
      powerMode == reset_power_pkg::MODE_TPDOWN |=> !powerCtl.brownoutDetector
                                                    && !powerCtl.comparators)
    else $error("monitors alive in total power-down");
  rc_off_a: assert property (
      isPowerDown(powerMode) && !(rcIsSystemClock && rtcEnable) |=> !powerCtl.rcOsc)
    else $error("rc oscillator left on");
  comp_off_a: assert property (comparatorPowerOff |=> !powerCtl.comparators)
    else $error("comparators left powered");
  pin_input_a: assert property (
      !resetPinEnable && !powerUpPhase && !pinSync |=> !pinDigitalIn)
    else $error("pin input level lost");
  boot_fetch_a: assert property (
      holdCount != '0 && bootStatusByte[0]
      |=> fetchAddress == {$past(bootVector), 8'h00})
    else $error("boot address not chosen");

  idle_wake_c: cover property (powerMode == reset_power_pkg::MODE_IDLE ##1
                               powerMode == reset_power_pkg::MODE_RUN);
  pdown_wake_c: cover property (powerMode == reset_power_pkg::MODE_PDOWN && wakeInterrupt);
  brownout_irq_c: cover property ($rose(brownoutIrq));
  tpd_reset_c: cover property (powerMode == reset_power_pkg::MODE_TPDOWN && anyReq);
  boot_release_c: cover property ($rose(cpuResetn) && fetchAddress != 16'h0000);

endmodule // reset_power_supervisor

//--- bench/supply_monitor_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// supply monitors and the board circuit on the shared reset pin
// ------------------------------------------------------------------
module supply_monitor_model (
  // clock
  input  wire logic clock,
  // commands from the bench
  input  wire logic rampUp,
  input  wire logic supplyLow,
  input  wire logic pinPullLow,
  // detector outputs and pin level
  output logic      powerOnRaw,
  output logic      brownoutRaw,
  output logic      sharedResetPin
);
  // levels move just after an edge, like slow analog comparators
  always_ff @(posedge clock) begin
    powerOnRaw     <= rampUp;
    brownoutRaw    <= supplyLow;   // only dips when the bench asks
    sharedResetPin <= !pinPullLow; // pull-up wins once released
  end
endmodule // supply_monitor_model

//--- bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                         clock = 1'b0;
  logic                         resetn = 1'b0;
  logic                         rampUp = 1'b1, supplyLow = 1'b0, pinPullLow = 1'b0;
  logic                         powerOnRaw, brownoutRaw, sharedResetPin;
  logic                         resetPinEnable = 1'b1; // fast clock needs the pin
  logic                         brownoutEnableConfig = 1'b0, brownoutAsInterrupt = 1'b0;
  logic [7:0]                   bootStatusByte = 8'h00, bootVector = 8'hA5;
  logic                         inSystemProgrammingMode = 1'b0;
  logic                         watchdogReset = 1'b0, softwareReset = 1'b0, breakReset = 1'b0;
  logic                         causeWrite = 1'b0, brownoutIrqClear = 1'b0;
  reset_power_pkg::cause_t      causeWriteData = 6'h00;
  reset_power_pkg::mode_req_t   modeRequest = 3'h0;
  logic                         interruptPending = 1'b0, wakeInterrupt = 1'b0;
  logic                         rcIsSystemClock = 1'b0, rtcEnable = 1'b0;
  logic                         comparatorPowerOff = 1'b0;
  reset_power_pkg::cause_t      resetCauseRegister;
  logic                         cpuResetn, brownoutIrq, pinDigitalIn;
  logic [15:0]                  fetchAddress;
  reset_power_pkg::power_mode_t powerMode;
  reset_power_pkg::power_ctl_t  powerCtl;
  int                           errTotal = 0, nCompared = 0;

  always #20 clock = ~clock;

  // short hold count keeps every reset episode brief
  reset_power_supervisor #(.RESET_HOLD_CYCLES(2)) u_reset_power_supervisor (
    .clock(clock), .resetn(resetn), .powerOnRaw(powerOnRaw), .brownoutRaw(brownoutRaw),
    .sharedResetPin(sharedResetPin), .resetPinEnable(resetPinEnable),
    .brownoutEnableConfig(brownoutEnableConfig), .brownoutAsInterrupt(brownoutAsInterrupt),
    .bootStatusByte(bootStatusByte), .bootVector(bootVector),
    .inSystemProgrammingMode(inSystemProgrammingMode), .watchdogReset(watchdogReset),
    .softwareReset(softwareReset), .breakReset(breakReset), .causeWrite(causeWrite),
    .causeWriteData(causeWriteData), .brownoutIrqClear(brownoutIrqClear),
    .modeRequest(modeRequest), .interruptPending(interruptPending),
    .wakeInterrupt(wakeInterrupt), .rcIsSystemClock(rcIsSystemClock), .rtcEnable(rtcEnable),
    .comparatorPowerOff(comparatorPowerOff), .resetCauseRegister(resetCauseRegister),
    .cpuResetn(cpuResetn), .brownoutIrq(brownoutIrq), .fetchAddress(fetchAddress),
    .pinDigitalIn(pinDigitalIn), .powerMode(powerMode), .powerCtl(powerCtl));

  supply_monitor_model u_supply_monitor_model (
    .clock(clock), .rampUp(rampUp), .supplyLow(supplyLow), .pinPullLow(pinPullLow),
    .powerOnRaw(powerOnRaw), .brownoutRaw(brownoutRaw), .sharedResetPin(sharedResetPin));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic note(input bit ok, input string what);
    nCompared++;
    if (!ok) begin
      errTotal++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask
  task automatic checkBit(input logic got, input logic exp, input string what);
    note(got === exp, what);
  endtask
  task automatic checkCause(input reset_power_pkg::cause_t exp);
    note(resetCauseRegister === exp, "cause flags");
  endtask
  task automatic checkAddr(input logic [15:0] exp);
    note(fetchAddress === exp, "fetch address");
  endtask
  task automatic checkMode(input reset_power_pkg::power_mode_t exp);
    note(powerMode === exp, "power mode");
  endtask
  task automatic checkCtl(input reset_power_pkg::power_ctl_t exp);
    note(powerCtl === exp, "power controls");
  endtask
  // checks land 1 ns after an edge so every register has settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic waitRelease();
    int i;
    i = 0;
    while (cpuResetn !== 1'b1 && i < 60) begin
      cyc(1);
      i++;
    end
    checkBit(cpuResetn, 1'b1, "reset not released");
  endtask
  task automatic doReset(input logic pinLow);
    @(posedge clock) begin
      resetn     <= 1'b0;
      rampUp     <= 1'b1;
      pinPullLow <= pinLow;
    end
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rampUp <= 1'b0;
  endtask
  task automatic writeCause(input reset_power_pkg::cause_t d);
    @(posedge clock) begin
      causeWrite     <= 1'b1;
      causeWriteData <= d;
    end
    @(posedge clock) causeWrite <= 1'b0;
    cyc(1);
  endtask
  task automatic reqMode(input reset_power_pkg::mode_req_t m);
    @(posedge clock) modeRequest <= m;
    @(posedge clock) modeRequest <= 3'h0;
    cyc(2);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testSources();
    reset_power_pkg::cause_t expC [3] = '{6'h08, 6'h0C, 6'h0E};
    writeCause(6'h00);
    checkCause(6'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock) begin
        bootStatusByte <= (k == 3) ? 8'h01 : 8'h00;
        if (k == 1) softwareReset <= 1'b1;
        else if (k == 2) breakReset <= 1'b1;
        else watchdogReset <= 1'b1;
      end
      @(posedge clock) begin
        watchdogReset <= 1'b0;
        softwareReset <= 1'b0;
        breakReset    <= 1'b0;
      end
      cyc(1);
      checkBit(cpuResetn, 1'b0, "reset not taken");
      waitRelease();
      if (k < 3) checkCause(expC[k]);
      checkAddr(k >= 2 ? 16'hA500 : 16'h0000);
    end
    writeCause(6'h33);
    checkCause(6'h02);
    writeCause(6'h3F);
    checkCause(6'h02);
    @(posedge clock) bootStatusByte <= 8'h00;
  endtask

  task automatic testPin();
    writeCause(6'h00);
    @(posedge clock) pinPullLow <= 1'b1;
    cyc(5);
    checkBit(cpuResetn, 1'b0, "pin reset");
    @(posedge clock) pinPullLow <= 1'b0;
    waitRelease();
    checkCause(6'h01);
    @(posedge clock) begin
      resetPinEnable <= 1'b0;
      pinPullLow     <= 1'b1;
    end
    cyc(6);
    checkBit(cpuResetn, 1'b1, "pin as input");
    checkBit(pinDigitalIn, 1'b0, "pin level low");
    @(posedge clock) pinPullLow <= 1'b0;
    cyc(6);
    checkBit(pinDigitalIn, 1'b1, "pin level high");
    checkCause(6'h01);
  endtask

  task automatic testBrownout();
    writeCause(6'h00);
    @(posedge clock) begin
      brownoutEnableConfig <= 1'b1;
      supplyLow            <= 1'b1;
    end
    cyc(2);
    checkBit(cpuResetn, 1'b1, "unsynchronised reset");
    cyc(4);
    checkBit(cpuResetn, 1'b0, "brownout reset");
    @(posedge clock) supplyLow <= 1'b0;
    waitRelease();
    checkCause(6'h10);
    @(posedge clock) begin
      brownoutAsInterrupt <= 1'b1;
      supplyLow           <= 1'b1;
    end
    cyc(6);
    checkBit(brownoutIrq, 1'b1, "brownout irq");
    checkBit(cpuResetn, 1'b1, "irq mode reset");
    @(posedge clock) supplyLow <= 1'b0;
    cyc(6);
    checkBit(brownoutIrq, 1'b1, "irq sticky");
    @(posedge clock) brownoutIrqClear <= 1'b1;
    @(posedge clock) brownoutIrqClear <= 1'b0;
    cyc(1);
    checkBit(brownoutIrq, 1'b0, "irq cleared");
    @(posedge clock) begin
      brownoutEnableConfig <= 1'b0;
      brownoutAsInterrupt  <= 1'b0;
      supplyLow            <= 1'b1;
    end
    cyc(8);
    checkBit(cpuResetn, 1'b1, "disabled brownout");
    @(posedge clock) supplyLow <= 1'b0;
    cyc(4);
  endtask

  task automatic testModes();
    @(posedge clock) begin
      brownoutEnableConfig <= 1'b1;
      rcIsSystemClock      <= 1'b1;
      rtcEnable            <= 1'b1;
    end
    reqMode(3'b100);
    checkMode(reset_power_pkg::MODE_IDLE);
    checkCtl(8'h7F);
    @(posedge clock) comparatorPowerOff <= 1'b1;
    cyc(1);
    checkCtl(8'h7B);
    @(posedge clock) comparatorPowerOff <= 1'b0;
    @(posedge clock) interruptPending <= 1'b1;
    @(posedge clock) interruptPending <= 1'b0;
    cyc(1);
    checkMode(reset_power_pkg::MODE_RUN);
    reqMode(3'b010);
    checkMode(reset_power_pkg::MODE_PDOWN);
    checkCtl(8'h1F);
    @(posedge clock) interruptPending <= 1'b1;
    @(posedge clock) interruptPending <= 1'b0;
    cyc(1);
    checkMode(reset_power_pkg::MODE_PDOWN);
    @(posedge clock) wakeInterrupt <= 1'b1;
    @(posedge clock) wakeInterrupt <= 1'b0;
    cyc(1);
    checkMode(reset_power_pkg::MODE_RUN);
    @(posedge clock) rtcEnable <= 1'b0;
    reqMode(3'b001);
    checkMode(reset_power_pkg::MODE_TPDOWN);
    checkCtl(8'h02);
    // waking by reset is the safe exit after a lowered supply
    @(posedge clock) softwareReset <= 1'b1;
    @(posedge clock) softwareReset <= 1'b0;
    cyc(1);
    checkMode(reset_power_pkg::MODE_RUN);
    waitRelease();
  endtask

  task automatic testPowerUpPin();
    @(posedge clock) begin
      resetPinEnable          <= 1'b0;
      inSystemProgrammingMode <= 1'b1;
    end
    doReset(1'b1);
    cyc(20);
    checkBit(cpuResetn, 1'b0, "power-up pin reset");
    @(posedge clock) pinPullLow <= 1'b0;
    waitRelease();
    checkBit(resetCauseRegister.powerOnFlag, 1'b1, "power-on flag");
    checkAddr(16'hA500);
    // a later episode without programming falls back to zero
    @(posedge clock) begin
      inSystemProgrammingMode <= 1'b0;
      watchdogReset           <= 1'b1;
    end
    @(posedge clock) watchdogReset <= 1'b0;
    cyc(1);
    waitRelease();
    checkAddr(16'h0000);
  endtask

  // ----------------------------------------------------------------
  // verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  task automatic giveVerdict();
    $display("compared %0d, wrong %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    doReset(1'b0);
    cyc(1);
    checkCause(6'h30);
    checkAddr(16'h0000);
    waitRelease();
    checkCause(6'h30);
    testSources();
    testPin();
    testBrownout();
    testModes();
    testPowerUpPin();
    giveVerdict();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clock);
    errTotal++;
    giveVerdict();
  end
endmodule // tb_top
